//--- design/pmic_gpio_defines.svh
`ifndef PMIC_GPIO_DEFINES_SVH
`define PMIC_GPIO_DEFINES_SVH

// Register addresses on the serial register port
`define CFG12_ADDR  8'h1b
`define CFG3_ADDR   8'h1c

// Power-up values of the two configuration registers
`define CFG12_RESET 8'h00
`define CFG3_RESET  8'h00

// Answer for an address that holds no register
`define UNMAPPED_RD 8'h00

// Pin slots in the pin vectors
`define PIN_ONE     0
`define PIN_TWO     1
`define PIN_THREE   2

`endif

//--- design/pmic_gpio_pkg.sv
package pmic_gpio_pkg;

	// Pins one and two configuration, bit 7 first
	typedef struct packed {
		logic pin_two_direction;      // 1 = output
		logic pin_one_direction;      // 1 = output
		logic pin_two_out_level;      // 1 = released high
		logic pin_one_out_level;      // 1 = released high
		logic pin_two_sense_polarity; // 1 = falling edge, high level
		logic pin_one_sense_polarity; // 1 = falling edge, high level
		logic pin_one_standby_ctrl;   // Pin one steers standby
		logic pin_one_buck_a_ctrl;    // Pin one steers buck a
	} cfg12_t;

	// Pin three and miscellaneous controls, bit 7 first
	typedef struct packed {
		logic pin_three_direction;    // 1 = output
		logic pin_three_out_level;    // 1 = released high
		logic always_on_reg_enable;   // Always-on regulator on
		logic charge_voltage_select;  // 0 = 4.20 V, 1 = 4.36 V
		logic backup_voltage_select;  // 0 = 3.1 V, 1 = 2.6 V
		logic pin_two_irq_enable;     // Pin two edge raises interrupt
		logic pin_one_irq_enable;     // Pin one edge raises interrupt
		logic pin_two_buck_b_ctrl;    // Pin two steers buck b
	} cfg3_t;

	// One access from the serial engine
	typedef struct packed {
		logic       wr;    // Write strobe, one cycle
		logic       rd;    // Read strobe, one cycle
		logic [7:0] addr;  // Register address
		logic [7:0] wdata; // Write data
	} reg_req_t;

	// Interrupt line state, one-hot
	typedef enum logic [2:0] {
		IRQ_IDLE  = 3'h1,
		IRQ_LOW   = 3'h2,
		IRQ_ARMED = 3'h4
	} irq_state_t;

	// Level sense: polarity 1 means active high
	function automatic logic level_active(input logic level, input logic pol);
		return level == pol;
	endfunction : level_active

	// Edge sense: polarity 0 rising, 1 falling
	function automatic logic edge_hit(input logic rise, input logic fall, input logic pol);
		return pol ? fall : rise;
	endfunction : edge_hit

endpackage : pmic_gpio_pkg

//--- design/pin_event_detect.sv
`timescale 1ns/10ps
`default_nettype none

module pin_event_detect #(
	parameter int WIDTH = 3
) (
	input  wire logic             mclk,      // System clock
	input  wire logic             rst,       // Synchronous reset
	input  wire logic [WIDTH-1:0] pin_async, // Raw pin levels
	output logic      [WIDTH-1:0] pin_level, // Synchronised levels
	output logic      [WIDTH-1:0] pin_rise,  // One-cycle rising pulse
	output logic      [WIDTH-1:0] pin_fall   // One-cycle falling pulse
);

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pin_event_detect needs at least one pin");
		end
	endgenerate

	logic [WIDTH-1:0] meta_reg;  // First stage, read by second only
	logic [WIDTH-1:0] sync_reg;  // Second stage
	logic [WIDTH-1:0] prev_reg;  // Last synchronised level
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_next;
	logic [WIDTH-1:0] prev_next;

	// Two stages before any logic looks, so each transition is one event
	always_comb begin
		meta_next = pin_async;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	// Idle pins read high: the line is pulled up outside
	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_reg <= '1;
			sync_reg <= '1;
			prev_reg <= '1;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// Edges from the settled stages only
	assign pin_level = sync_reg;
	assign pin_rise  = sync_reg & ~prev_reg;
	assign pin_fall  = ~sync_reg & prev_reg;

endmodule : pin_event_detect

`default_nettype wire

//--- design/pmic_gpio_config_regs.sv
// What this block does
// - Register 0x1B, pins one/two, fully read/write
// - Direction bits: zero input, one output
// - Output level bits act only as output
// - Polarity picks rising/low or falling/high
// - Pin one steers standby and buck a
// - Enabled pin edge pulls interrupt low
// - Pin two steers buck b on/off
// - Always-on regulator enable bit
// - Charge voltage safety select bit
// - Backup supply voltage select bit
// - Release needs two edges then read
// - Undervoltage or output reconfiguration releases interrupt
// - Converter on/standby needs both commands
// - Pins are open-drain, high means released
`timescale 1ns/10ps
`default_nettype none
`include "pmic_gpio_defines.svh"

module pmic_gpio_config_regs (
	input  wire logic                      mclk,             // 200 MHz clock
	input  wire logic                      rst,              // Sync reset
	input  wire pmic_gpio_pkg::reg_req_t   reg_req,          // Register access
	output logic [7:0]                     reg_rdata,        // Read data
	input  wire logic [2:0]                pin_in,           // Pin levels
	output logic [2:0]                     pin_out,          // Pin drive value
	output logic [2:0]                     pin_oe,           // Pin pull low
	input  wire logic                      input_undervoltage_lockout_event,       // Undervoltage lockout
	input  wire logic                      buck_a_on_cmd,    // Register on, buck a
	input  wire logic                      buck_b_on_cmd,    // Register on, buck b
	input  wire logic                      buck_standby_cmd, // Register standby
	output logic                           buck_a_enable,    // Buck a on
	output logic                           buck_b_enable,    // Buck b on
	output logic                           buck_a_standby,   // Buck a standby
	output logic                           buck_b_standby,   // Buck b standby
	output logic                           always_on_reg_enable,  // Regulator on
	output logic                           charge_voltage_select, // Charge limit
	output logic                           backup_voltage_select, // Backup level
	output logic                           irq_n             // Host interrupt
);

	pmic_gpio_pkg::cfg12_t     cfg12_reg, cfg12_next; // Pins one/two
	pmic_gpio_pkg::cfg3_t      cfg3_reg, cfg3_next;   // Pin three/misc
	logic [7:0]                rdata_reg, rdata_next; // Read capture
	pmic_gpio_pkg::irq_state_t irq_reg, irq_next;     // Interrupt state
	logic                      src_reg, src_next;     // 1 = pin two raised it
	logic [3:0]                buck_reg, buck_next;   // a_en, b_en, a_sby, b_sby
	logic [2:0]                oe_reg, oe_next;       // Pull-low drive
	logic [2:0]                pin_level, pin_rise, pin_fall;
	logic [2:0]                dir;                   // Pin is output
	logic [2:0]                pol;                   // Sense polarity
	logic [1:0]                trig;                  // Enabled edge on pin one/two
	logic                      src_edge;              // Any edge on source pin
	logic                      src_out;               // Source pin now output
	logic                      hit12, hit3;           // Address decode

	// Synchronisers and edge finders for all three pins
	pin_event_detect #(
		.WIDTH(3)
	) u_pins (
		.mclk      (mclk),
		.rst       (rst),
		.pin_async (pin_in),
		.pin_level (pin_level),
		.pin_rise  (pin_rise),
		.pin_fall  (pin_fall)
	);

	// Field gathering
	assign dir  = {cfg3_reg.pin_three_direction, cfg12_reg.pin_two_direction,
		cfg12_reg.pin_one_direction};
	assign pol  = {1'h0, cfg12_reg.pin_two_sense_polarity, cfg12_reg.pin_one_sense_polarity};
	assign hit12 = reg_req.addr == `CFG12_ADDR;
	assign hit3  = reg_req.addr == `CFG3_ADDR;

	// Register writes and read capture
	always_comb begin
		cfg12_next = cfg12_reg;
		cfg3_next  = cfg3_reg;
		rdata_next = rdata_reg;
		if (reg_req.wr && hit12) begin
			cfg12_next = reg_req.wdata;
		end
		if (reg_req.wr && hit3) begin
			cfg3_next = reg_req.wdata;
		end
		if (reg_req.rd) begin
			// Unmapped addresses answer zero
			if (hit12) begin
				rdata_next = cfg12_reg;
			end else if (hit3) begin
				rdata_next = cfg3_reg;
			end else begin
				rdata_next = `UNMAPPED_RD;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg12_reg <= `CFG12_RESET;
			cfg3_reg  <= `CFG3_RESET;
			rdata_reg <= `UNMAPPED_RD;
		end else begin
			cfg12_reg <= cfg12_next;
			cfg3_reg  <= cfg3_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// Trigger only on input pins with interrupt enabled
	always_comb begin
		trig[0] = !dir[`PIN_ONE] && cfg3_reg.pin_one_irq_enable &&
			pmic_gpio_pkg::edge_hit(pin_rise[`PIN_ONE], pin_fall[`PIN_ONE], pol[`PIN_ONE]);
		trig[1] = !dir[`PIN_TWO] && cfg3_reg.pin_two_irq_enable &&
			pmic_gpio_pkg::edge_hit(pin_rise[`PIN_TWO], pin_fall[`PIN_TWO], pol[`PIN_TWO]);
		src_edge = src_reg ? (pin_rise[`PIN_TWO] | pin_fall[`PIN_TWO])
			: (pin_rise[`PIN_ONE] | pin_fall[`PIN_ONE]);
		src_out = src_reg ? dir[`PIN_TWO] : dir[`PIN_ONE];
	end

	// Interrupt line: low on trigger, armed by the return edge, freed by a read
	always_comb begin
		irq_next = irq_reg;
		src_next = src_reg;
		unique case (irq_reg)
			pmic_gpio_pkg::IRQ_IDLE: begin
				if (|trig) begin
					irq_next = pmic_gpio_pkg::IRQ_LOW;
					src_next = !trig[0];
				end
			end
			pmic_gpio_pkg::IRQ_LOW: begin
				// Reads before the second edge do not release the line
				if (input_undervoltage_lockout_event || src_out) begin
					irq_next = pmic_gpio_pkg::IRQ_IDLE;
				end else if (src_edge) begin
					irq_next = pmic_gpio_pkg::IRQ_ARMED;
				end
			end
			pmic_gpio_pkg::IRQ_ARMED: begin
				// Extra edges stay armed: no toggling without a read
				if (input_undervoltage_lockout_event || src_out || reg_req.rd) begin
					irq_next = pmic_gpio_pkg::IRQ_IDLE;
				end
			end
		endcase
		// A new trigger in the releasing cycle wins over the release
		if (irq_reg != pmic_gpio_pkg::IRQ_IDLE && irq_next == pmic_gpio_pkg::IRQ_IDLE
			&& |trig) begin
			irq_next = pmic_gpio_pkg::IRQ_LOW;
			src_next = !trig[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_reg <= pmic_gpio_pkg::IRQ_IDLE;
			src_reg <= 1'h0;
		end else begin
			irq_reg <= irq_next;
			src_reg <= src_next;
		end
	end

	assign irq_n = irq_reg != pmic_gpio_pkg::IRQ_LOW && irq_reg != pmic_gpio_pkg::IRQ_ARMED;

	// Converter arbitration: pin command counts only on an input pin that steers it
	always_comb begin
		logic pin_a_on;
		logic pin_b_on;
		logic pin_sby;
		pin_a_on = 1'h1;
		pin_b_on = 1'h1;
		pin_sby  = 1'h1;
		if (!dir[`PIN_ONE] && cfg12_reg.pin_one_buck_a_ctrl) begin
			pin_a_on = pmic_gpio_pkg::level_active(pin_level[`PIN_ONE], pol[`PIN_ONE]);
		end
		if (!dir[`PIN_TWO] && cfg3_reg.pin_two_buck_b_ctrl) begin
			pin_b_on = pmic_gpio_pkg::level_active(pin_level[`PIN_TWO], pol[`PIN_TWO]);
		end
		if (!dir[`PIN_ONE] && cfg12_reg.pin_one_standby_ctrl) begin
			pin_sby = pmic_gpio_pkg::level_active(pin_level[`PIN_ONE], pol[`PIN_ONE]);
		end
		buck_next[3] = buck_a_on_cmd && pin_a_on;
		buck_next[2] = buck_b_on_cmd && pin_b_on;
		buck_next[1] = buck_standby_cmd && pin_sby;
		buck_next[0] = buck_standby_cmd && pin_sby;
		// Open-drain: pull low only for an output set low, else released
		oe_next = dir & ~{cfg3_reg.pin_three_out_level, cfg12_reg.pin_two_out_level,
			cfg12_reg.pin_one_out_level};
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			buck_reg <= 4'h0;
			oe_reg   <= 3'h0;
		end else begin
			buck_reg <= buck_next;
			oe_reg   <= oe_next;
		end
	end

	assign buck_a_enable  = buck_reg[3];
	assign buck_b_enable  = buck_reg[2];
	assign buck_a_standby = buck_reg[1];
	assign buck_b_standby = buck_reg[0];
	assign pin_oe         = oe_reg;
	assign pin_out        = 3'h0; // Only ever drives low
	// Straight from register flops
	assign always_on_reg_enable  = cfg3_reg.always_on_reg_enable;
	assign charge_voltage_select = cfg3_reg.charge_voltage_select;
	assign backup_voltage_select = cfg3_reg.backup_voltage_select;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_irq_set_edge: assert property (irq_n && |trig |=> !irq_n)
		else $error("enabled edge did not pull interrupt low");
	a_irq_no_early: assert property (
		irq_reg == pmic_gpio_pkg::IRQ_LOW && !input_undervoltage_lockout_event && !src_out |=> !irq_n)
		else $error("interrupt released before second edge");
	a_irq_read_free: assert property (
		irq_reg == pmic_gpio_pkg::IRQ_ARMED && reg_req.rd && !(|trig) |=> irq_n)
		else $error("read after two edges did not release interrupt");
	a_irq_input_undervoltage_lockout_free: assert property (!irq_n && input_undervoltage_lockout_event && !(|trig) |=> irq_n)
		else $error("undervoltage did not release interrupt");
	a_buck_both_on: assert property (!buck_a_on_cmd |=> !buck_a_enable)
		else $error("buck a on without register command");
	a_sby_both: assert property (!buck_standby_cmd |=> !buck_a_standby && !buck_b_standby)
		else $error("standby without register command");
	a_pin_od_low: assert property (
		reg_req.wr && hit12 && reg_req.wdata[7:6] == 2'h3
		&& reg_req.wdata[5:4] == 2'h0 |=> ##1 pin_oe[1:0] == 2'h3)
		else $error("output set low is not pulled low");
	a_pin_od_rel: assert property (
		reg_req.wr && hit12 && reg_req.wdata[5:4] == 2'h3 |=> ##1 pin_oe[1:0] == 2'h0)
		else $error("output set high is not released");
	a_cfg_readback: assert property (
		reg_req.wr && hit12 ##1 reg_req.rd && hit12 && !reg_req.wr
		|=> reg_rdata == $past(reg_req.wdata, 2))
		else $error("register 0x1b readback mismatch");
	a_misc_bits: assert property (
		reg_req.wr && hit3 |=> always_on_reg_enable == $past(reg_req.wdata[5])
		&& charge_voltage_select == $past(reg_req.wdata[4])
		&& backup_voltage_select == $past(reg_req.wdata[3]))
		else $error("misc control bits do not follow write");

	c_irq_cycle: cover property (irq_reg == pmic_gpio_pkg::IRQ_ARMED && reg_req.rd ##1 irq_n);
	c_irq_input_undervoltage_lockout: cover property (!irq_n && input_undervoltage_lockout_event);
	c_standby: cover property (buck_a_standby && buck_a_enable);
	c_pin_ctrl: cover property (buck_a_on_cmd && !buck_a_enable);

endmodule : pmic_gpio_config_regs

`default_nettype wire

//--- testbench/pin_world.sv
`timescale 1ns/10ps
`default_nettype none

// Board side of the three pins: pull-ups plus outside drivers
module pin_world (
	input  wire logic [2:0] pin_oe,   // Device pulls pin low
	input  wire logic [2:0] pin_out,  // Device drive value
	input  wire logic [2:0] ext_low,  // Outside source pulls low
	output logic      [2:0] pin_wire  // Resolved pin levels
);
	// Wired-AND with pull-up, so a released pin reads high and never holds the old level
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_wire[i] = ((pin_oe[i] && !pin_out[i]) || ext_low[i]) ? 1'h0 : 1'h1;
		end
	end
endmodule : pin_world

`default_nettype wire

//--- testbench/pmic_gpio_config_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmic_gpio_defines.svh"

module pmic_gpio_config_regs_bench;
	logic                    mclk;       // 200 MHz clock
	logic                    rst;        // Sync reset
	pmic_gpio_pkg::reg_req_t reg_req;    // Register access
	logic [7:0]              reg_rdata;  // Read data
	logic [2:0]              pin_wire;   // Resolved pins
	logic [2:0]              pin_out;    // Device drive value
	logic [2:0]              pin_oe;     // Device pull low
	logic [2:0]              ext_low;    // Outside pull low
	logic                    input_undervoltage_lockout_event; // Undervoltage lockout
	logic                    a_on;       // Register on, buck a
	logic                    b_on;       // Register on, buck b
	logic                    sby;        // Register standby
	logic                    a_en;       // Buck a on
	logic                    b_en;       // Buck b on
	logic                    sby_a;      // Buck a standby
	logic                    sby_b;      // Buck b standby
	logic                    aon;        // Always-on regulator
	logic                    chg;        // Charge limit
	logic                    bkp;        // Backup level
	logic                    irq_n;      // Host interrupt
	logic                    rd_d;       // Read taken last edge
	logic [7:0]              d;          // Random data
	logic [7:0]              exp_q[$];   // Expected read data
	int                      n_fail;     // Mismatches
	int                      tests_run;  // Comparisons

	pmic_gpio_config_regs dut (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.pin_in(pin_wire), .pin_out(pin_out), .pin_oe(pin_oe), .input_undervoltage_lockout_event(input_undervoltage_lockout_event),
		.buck_a_on_cmd(a_on), .buck_b_on_cmd(b_on), .buck_standby_cmd(sby),
		.buck_a_enable(a_en), .buck_b_enable(b_en), .buck_a_standby(sby_a),
		.buck_b_standby(sby_b), .always_on_reg_enable(aon), .charge_voltage_select(chg),
		.backup_voltage_select(bkp), .irq_n(irq_n));

	pin_world board (.pin_oe(pin_oe), .pin_out(pin_out), .ext_low(ext_low), .pin_wire(pin_wire));

	// Free-running clock
	initial begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end

	// Verdict and end of run, shared with the watchdog
	task automatic tally_and_finish();
		n_fail += exp_q.size(); // Notes that no read ever answered
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// Byte comparison, four-state exact
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_byte

	// Single-bit comparison
	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_byte({7'h0, got}, {7'h0, exp}, what);
	endtask : chk_bit

	// Wait whole cycles, then sample mid-cycle where outputs are settled
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : cyc

	// One strobe cycle on the register port
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] dat);
		@(posedge mclk);
		reg_req <= '{wr: w, rd: !w, addr: a, wdata: dat};
		@(posedge mclk);
		reg_req <= '0;
	endtask : access

	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		access(1'h1, a, dat);
	endtask : wr

	// Note the expected byte, then strobe the read
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		access(1'h0, a, 8'h00);
	endtask : rd

	// Write then read the same register on the very next edge
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] dat);
		exp_q.push_back(dat);
		@(posedge mclk);
		reg_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: dat};
		@(posedge mclk);
		reg_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		reg_req <= '0;
	endtask : wr_rd

	// Two writes spaced so stale pin edges die out before enables land
	task automatic setup(input logic [7:0] b, input logic [7:0] c);
		wr(`CFG12_ADDR, b);
		cyc(6);
		wr(`CFG3_ADDR, c);
		cyc(6);
	endtask : setup

	// Change outside pin drivers and let sync plus detect settle
	task automatic drive(input logic [2:0] v);
		@(posedge mclk);
		ext_low <= v;
		cyc(6);
	endtask : drive

	// Read data is registered; check it one cycle after the strobe
	always @(posedge mclk) rd_d <= reg_req.rd;
	always @(negedge mclk) begin
		if (rd_d === 1'h1 && exp_q.size() > 0) begin
			chk_byte(reg_rdata, exp_q.pop_front(), "read data");
		end
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#50000;
		n_fail++;
		$display("wrong value at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	// Main sequence
	initial begin
		void'($urandom(63));
		rst = 1'h1;
		reg_req = '0;
		ext_low = 3'h0;
		input_undervoltage_lockout_event = 1'h0;
		a_on = 1'h0;
		b_on = 1'h0;
		sby = 1'h0;
		repeat (5) @(posedge mclk);
		rst <= 1'h0;
		rd(`CFG12_ADDR, `CFG12_RESET);
		rd(`CFG3_ADDR, `CFG3_RESET);
		rd(8'h55, `UNMAPPED_RD);
		// Random fills; a write to the next, unmapped address must not land
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			if (i[0]) d = d & 8'hf9; // Interrupt enables kept off here
			wr(i[0] ? `CFG3_ADDR : `CFG12_ADDR, d);
			wr(8'h1d, ~d);
			rd(i[0] ? `CFG3_ADDR : `CFG12_ADDR, d);
			if (i[0]) begin
				cyc(1);
				chk_bit(aon, d[5], "always-on enable");
				chk_bit(chg, d[4], "charge select");
				chk_bit(bkp, d[3], "backup select");
			end
		end
		// Write and read back to back, no idle cycle between
		d = 8'($urandom);
		wr_rd(`CFG12_ADDR, d);
		d = 8'($urandom);
		wr_rd(`CFG3_ADDR, d & 8'hf9);
		cyc(1);
		// Open drain: pulled low only as output with low level
		setup(8'hc0, 8'h80);
		chk_byte({5'h0, pin_oe}, 8'h07, "outputs low");
		chk_byte({5'h0, pin_wire}, 8'h00, "wires low");
		setup(8'hf0, 8'hc0);
		chk_byte({5'h0, pin_oe}, 8'h00, "outputs released");
		setup(8'h30, 8'h40);
		chk_byte({5'h0, pin_oe | pin_out}, 8'h00, "inputs undriven");
		// Pin one, rising sense, interrupt enabled
		setup(8'h00, 8'h02);
		drive(3'h1);
		chk_bit(irq_n, 1'h1, "wrong edge");
		drive(3'h0);
		chk_bit(irq_n, 1'h0, "pin one trigger");
		rd(`CFG3_ADDR, 8'h02);
		cyc(2);
		chk_bit(irq_n, 1'h0, "early read");
		drive(3'h1);
		drive(3'h0);
		chk_bit(irq_n, 1'h0, "armed, edges only");
		rd(8'h55, `UNMAPPED_RD);
		cyc(2);
		chk_bit(irq_n, 1'h1, "read release");
		// Pin two, falling sense; undervoltage and output releases
		setup(8'h08, 8'h04);
		drive(3'h2);
		chk_bit(irq_n, 1'h0, "pin two trigger");
		@(posedge mclk) input_undervoltage_lockout_event <= 1'h1;
		@(posedge mclk) input_undervoltage_lockout_event <= 1'h0;
		cyc(1);
		chk_bit(irq_n, 1'h1, "undervoltage release");
		drive(3'h0);
		chk_bit(irq_n, 1'h1, "rising ignored");
		drive(3'h2);
		chk_bit(irq_n, 1'h0, "retrigger");
		wr(`CFG12_ADDR, 8'h88);
		cyc(2);
		chk_bit(irq_n, 1'h1, "output release");
		setup(8'h00, 8'h00);
		drive(3'h0);
		chk_bit(irq_n, 1'h1, "interrupt disabled");
		// Buck a steered by pin one, low active
		setup(8'h01, 8'h00);
		@(posedge mclk) a_on <= 1'h1;
		cyc(2);
		chk_bit(a_en, 1'h0, "pin disagrees");
		drive(3'h1);
		chk_bit(a_en, 1'h1, "both agree");
		setup(8'h03, 8'h00);
		@(posedge mclk) sby <= 1'h1;
		cyc(2);
		chk_byte({6'h0, sby_a, sby_b}, 8'h03, "standby both");
		@(posedge mclk) a_on <= 1'h0;
		cyc(2);
		chk_bit(a_en, 1'h0, "register off");
		// Buck b steered by pin two, high active
		setup(8'h08, 8'h01);
		@(posedge mclk) b_on <= 1'h1;
		cyc(2);
		chk_bit(b_en, 1'h1, "buck b on");
		drive(3'h3);
		chk_bit(b_en, 1'h0, "buck b pin off");
		tally_and_finish();
	end
endmodule : pmic_gpio_config_regs_bench

`default_nettype wire
